// ### logic/sfb_pkg.sv
`default_nettype none
package sfb_pkg;

  // ****************************************
  // Register indices, byte address is index times four
  // ****************************************
  localparam logic [8:0] IDX_INDIRECT_DATA_PORT   = 9'h180;
  localparam logic [8:0] IDX_TIMER_OPTION_CONTROL = 9'h181;
  localparam logic [8:0] IDX_PROGRAM_COUNTER_LOW  = 9'h182;
  localparam logic [8:0] IDX_CORE_STATUS_FLAGS    = 9'h183;
  localparam logic [8:0] IDX_INDIRECT_POINTER     = 9'h184;
  localparam logic [8:0] IDX_PORT_A_DIRECTION     = 9'h185;
  localparam logic [8:0] IDX_PORT_C_DIRECTION     = 9'h187;
  localparam logic [8:0] IDX_PC_HIGH_LATCH        = 9'h18a;
  localparam logic [8:0] IDX_INTERRUPT_CONTROL    = 9'h18b;
  localparam logic [6:0] FILE_STATUS              = 7'h03;

  // ****************************************
  // Status and interrupt-control bit positions and reset values
  // ****************************************
  localparam int BIT_INDIRECT_BANK = 7;
  localparam int BIT_TIMEOUT       = 4;
  localparam int BIT_POWER_DOWN    = 3;
  localparam int BIT_ZERO          = 2;
  localparam int BIT_DIGIT_CARRY   = 1;
  localparam int BIT_CARRY         = 0;
  localparam int BIT_PORT_CHANGE   = 0;
  localparam logic [7:0] RST_STATUS    = 8'h18;
  localparam logic [7:0] RST_OPTION    = 8'hff;
  localparam logic [7:0] RST_BYTE_ZERO = 8'h00;
  localparam logic [5:0] RST_DIRECTION = 6'h3f;
  localparam logic [4:0] RST_PC_HIGH   = 5'h00;

  // ****************************************
  // Core operations
  // ****************************************
  typedef enum logic [3:0] {
    OP_ADD   = 4'h0,
    OP_SUB   = 4'h1,
    OP_AND   = 4'h2,
    OP_IOR   = 4'h3,
    OP_XOR   = 4'h4,
    OP_MOVF  = 4'h5,
    OP_RLF   = 4'h6,
    OP_RRF   = 4'h7,
    OP_CLEAR_FILE_INSTR  = 4'h8,
    OP_BSF   = 4'h9,
    OP_BCF   = 4'ha,
    OP_NIBBLE_SWAP_INSTR = 4'hb,
    OP_MOVE_FROM_W_INSTR = 4'hc
  } sfb_op_t;

  typedef struct packed {
    logic       valid;
    sfb_op_t    op;
    logic [6:0] file_addr;
    logic [2:0] bit_sel;
    logic [7:0] w_val;
    logic [7:0] f_val;
  } sfb_core_op_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] value;
  } sfb_core_res_t;

  typedef struct packed {
    logic watchdog_clear_instr;
    logic sleep_instr;
    logic watchdog_timeout;
    logic warm_reset;
  } sfb_events_t;

  typedef struct packed {
    logic [7:0] res;
    logic       z;
    logic       dc;
    logic       c;
    logic       upd_z;
    logic       upd_dc;
    logic       upd_c;
  } sfb_alu_t;

endpackage
`default_nettype wire

// ### logic/sfb_status_bank.sv
// Function
// R1 - Flag writes ignored when instruction updates flags
// R2 - Timeout and power-down flags not software writable
// R3 - Clear of status gives 000u u1uu
// R4 - Software alters status with flagless instructions
// R5 - Subtract carry flags are inverted borrows
// R6 - Bit 7 selects indirect bank pair
// R7 - Bits 6-5 select direct data bank
// R8 - Timeout flag set/cleared by its events
// R9 - Power-down flag set/cleared by its events
// R10 - Zero flag follows zero result
// R11 - Digit carry from bit 3 on add
// R12 - Carry from bit 7 on add
// R13 - Rotates load carry with shifted bit
// R14 - Reset clears port-change flag, mismatch sets it
// R15 - Warm resets keep port comparison latch
// R16 - High latch loads counter on low write
// R17 - Writable status bits take writes same cycle
`default_nettype none
module sfb_status_bank
  import sfb_pkg::*;
(
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst_b,
  // Avalon-MM slave
  input  wire logic [11:0]   i_avs_address,
  input  wire logic          i_avs_read,
  input  wire logic          i_avs_write,
  input  wire logic [31:0]   i_avs_writedata,
  input  wire logic [3:0]    i_avs_byteenable,
  output logic      [31:0]   o_avs_readdata,
  output logic               o_avs_waitrequest,
  // Core datapath
  input  wire sfb_core_op_t  i_core_op,
  input  wire sfb_events_t   i_events,
  output sfb_core_res_t      o_core_res,
  // Pins
  input  wire logic [5:0]    i_port_a_pins,
  // Addressing and state
  output logic      [7:0]    o_status,
  output logic      [8:0]    o_indirect_addr,
  output logic      [8:0]    o_direct_bank_base,
  output logic      [12:0]   o_pc,
  output logic      [7:0]    o_timer_option,
  output logic      [5:0]    o_port_a_dir,
  output logic      [5:0]    o_port_c_dir,
  output logic      [7:0]    o_interrupt_control
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0]    status;
    logic [7:0]    option;
    logic [7:0]    program_counter_low;
    logic [4:0]    pc_high;
    logic [7:0]    indirect_pointer;
    logic [5:0]    port_a_direction;
    logic [5:0]    port_c_direction;
    logic [4:0]    program_counter_high_latch;
    logic [7:0]    interrupt_control;
    logic [5:0]    cmp_latch;
    logic [5:0]    sync1;
    logic [5:0]    sync2;
    logic [5:0]    sync3;
    logic [5:0]    pins;
    logic          primed;
    logic          ack;
    logic [7:0]    rdata;
    sfb_core_res_t res;
  } sfb_state_t;

  sfb_state_t st;
  sfb_state_t next_st;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [8:0] reg_index(input logic [11:0] addr);
    return addr[10:2];
  endfunction

  function automatic sfb_alu_t alu(input sfb_op_t op, input logic [7:0] w,
                                   input logic [7:0] f, input logic [2:0] b,
                                   input logic c_in);
    sfb_alu_t   a;
    logic [8:0] sum;
    logic [4:0] nib;
    a = '0;
    sum = '0;
    nib = '0;
    unique case (op)
      OP_ADD: begin
        sum = {1'b0, f} + {1'b0, w};
        nib = {1'b0, f[3:0]} + {1'b0, w[3:0]};
        a.res = sum[7:0];
        a.c = sum[8]; // R12
        a.dc = nib[4]; // R11
        {a.upd_z, a.upd_dc, a.upd_c} = 3'b111;
      end
      OP_SUB: begin
        // Adding the two's complement yields carry = not borrow
        sum = {1'b0, f} + {1'b0, ~w} + 9'h001;
        nib = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
        a.res = sum[7:0];
        a.c = sum[8]; // R5
        a.dc = nib[4]; // R5
        {a.upd_z, a.upd_dc, a.upd_c} = 3'b111;
      end
      OP_AND: begin
        a.res = f & w;
        a.upd_z = 1'b1;
      end
      OP_IOR: begin
        a.res = f | w;
        a.upd_z = 1'b1;
      end
      OP_XOR: begin
        a.res = f ^ w;
        a.upd_z = 1'b1;
      end
      OP_MOVF: begin
        a.res = f;
        a.upd_z = 1'b1;
      end
      OP_RLF: begin
        a.res = {f[6:0], c_in};
        a.c = f[7]; // R13
        a.upd_c = 1'b1;
      end
      OP_RRF: begin
        a.res = {c_in, f[7:1]};
        a.c = f[0]; // R13
        a.upd_c = 1'b1;
      end
      OP_CLEAR_FILE_INSTR: begin
        a.res = 8'h00;
        a.upd_z = 1'b1;
      end
      OP_BSF: a.res = f | (8'h01 << b);
      OP_BCF: a.res = f & ~(8'h01 << b);
      OP_NIBBLE_SWAP_INSTR: a.res = {f[3:0], f[7:4]};
      OP_MOVE_FROM_W_INSTR: a.res = w;
      default: a.res = f;
    endcase
    a.z = (a.res == 8'h00); // R10
    return a;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  logic          bus_req;
  logic          bus_wr;
  logic [8:0]    bus_idx;
  logic [7:0]    wbyte;
  logic          dest_status;
  logic [7:0]    f_operand;
  sfb_alu_t      a;

  always_comb begin
    next_st = st;
    bus_req = i_avs_read | i_avs_write;
    bus_idx = reg_index(i_avs_address);
    wbyte = i_avs_writedata[7:0];
    bus_wr = i_avs_write & ~st.ack & i_avs_byteenable[0];
    dest_status = i_core_op.valid && i_core_op.file_addr == FILE_STATUS;
    f_operand = dest_status ? st.status : i_core_op.f_val;
    a = alu(i_core_op.op, i_core_op.w_val, f_operand, i_core_op.bit_sel,
            st.status[BIT_CARRY]);

    // Pin synchroniser; a change counts once stages two and three agree
    next_st.sync1 = i_port_a_pins;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    if (st.sync2 == st.sync3) begin
      next_st.pins = st.sync3;
    end
    // First cycle after power-up loads the reference from the filtered pins, still zero from reset
    next_st.primed = 1'b1;
    if (!st.primed) begin
      next_st.cmp_latch = st.pins;
    end

    // Bus: one wait state, read data registered before waitrequest drops
    next_st.ack = bus_req & ~st.ack;
    if (bus_req && !st.ack && i_avs_read) begin
      unique case (bus_idx)
        IDX_TIMER_OPTION_CONTROL: next_st.rdata = st.option;
        IDX_PROGRAM_COUNTER_LOW:  next_st.rdata = st.program_counter_low;
        IDX_CORE_STATUS_FLAGS:    next_st.rdata = st.status;
        IDX_INDIRECT_POINTER:     next_st.rdata = st.indirect_pointer;
        IDX_PORT_A_DIRECTION:     next_st.rdata = {2'b00, st.port_a_direction};
        IDX_PORT_C_DIRECTION:     next_st.rdata = {2'b00, st.port_c_direction};
        IDX_PC_HIGH_LATCH:        next_st.rdata = {3'b000, st.program_counter_high_latch};
        IDX_INTERRUPT_CONTROL:    next_st.rdata = st.interrupt_control;
        default:                  next_st.rdata = 8'h00;
      endcase
      // Reading the control register refreshes the comparison reference
      if (bus_idx == IDX_INTERRUPT_CONTROL) begin
        next_st.cmp_latch = st.pins;
      end
    end
    if (bus_wr) begin
      unique case (bus_idx)
        IDX_TIMER_OPTION_CONTROL: next_st.option = wbyte;
        IDX_PROGRAM_COUNTER_LOW: begin
          next_st.program_counter_low = wbyte;
          next_st.pc_high = st.program_counter_high_latch; // R16
        end
        IDX_CORE_STATUS_FLAGS: begin
          next_st.status[7:5] = wbyte[7:5]; // R17
          next_st.status[2:0] = wbyte[2:0]; // R2
        end
        IDX_INDIRECT_POINTER:     next_st.indirect_pointer = wbyte;
        IDX_PORT_A_DIRECTION:     next_st.port_a_direction = wbyte[5:0];
        IDX_PORT_C_DIRECTION:     next_st.port_c_direction = wbyte[5:0];
        IDX_PC_HIGH_LATCH:        next_st.program_counter_high_latch = wbyte[4:0];
        IDX_INTERRUPT_CONTROL:    next_st.interrupt_control = wbyte;
        default: begin
        end
      endcase
    end

    // Core operation overrides a same-cycle bus write to status
    next_st.res.valid = i_core_op.valid;
    if (i_core_op.valid) begin
      next_st.res.value = a.res;
      if (dest_status) begin
        next_st.status[7:5] = a.res[7:5]; // R3
        if (!(a.upd_z || a.upd_dc || a.upd_c)) begin // R1
          next_st.status[2:0] = a.res[2:0]; // R17
        end
      end
      if (a.upd_z) begin
        next_st.status[BIT_ZERO] = a.z; // R1
      end
      if (a.upd_dc) begin
        next_st.status[BIT_DIGIT_CARRY] = a.dc; // R1
      end
      if (a.upd_c) begin
        next_st.status[BIT_CARRY] = a.c; // R1
      end
    end

    // Reset-status events
    if (i_events.watchdog_timeout) begin
      next_st.status[BIT_TIMEOUT] = 1'b0; // R8
    end
    if (i_events.sleep_instr) begin
      next_st.status[BIT_TIMEOUT] = 1'b1; // R8
      next_st.status[BIT_POWER_DOWN] = 1'b0; // R9
    end
    if (i_events.watchdog_clear_instr) begin
      next_st.status[BIT_TIMEOUT] = 1'b1; // R8
      next_st.status[BIT_POWER_DOWN] = 1'b1; // R9
    end

    // Port-change flag: a mismatch wins over a software clear
    if (st.primed && st.pins != st.cmp_latch) begin
      next_st.interrupt_control[BIT_PORT_CHANGE] = 1'b1; // R14
    end

    // Warm reset: flags and comparison latch survive, the flag clears
    if (i_events.warm_reset) begin
      next_st.status[7:5] = 3'b000;
      next_st.option = RST_OPTION;
      next_st.program_counter_low = RST_BYTE_ZERO;
      next_st.pc_high = RST_PC_HIGH;
      next_st.port_a_direction = RST_DIRECTION;
      next_st.port_c_direction = RST_DIRECTION;
      next_st.program_counter_high_latch = RST_PC_HIGH;
      next_st.interrupt_control = RST_BYTE_ZERO; // R14
      next_st.cmp_latch = st.cmp_latch; // R15
      next_st.res = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= '0;
      st.status <= RST_STATUS;
      st.option <= RST_OPTION;
      st.port_a_direction <= RST_DIRECTION;
      st.port_c_direction <= RST_DIRECTION;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~st.ack;
  assign o_avs_readdata = {24'h00_0000, st.rdata};
  assign o_core_res = st.res;
  assign o_status = st.status;
  assign o_indirect_addr = {st.status[BIT_INDIRECT_BANK], st.indirect_pointer}; // R6
  assign o_direct_bank_base = {st.status[6:5], 7'h00}; // R7
  assign o_pc = {st.pc_high, st.program_counter_low};
  assign o_timer_option = st.option;
  assign o_port_a_dir = st.port_a_direction;
  assign o_port_c_dir = st.port_c_direction;
  assign o_interrupt_control = st.interrupt_control;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  logic quiet;
  assign quiet = ~i_events.watchdog_clear_instr & ~i_events.sleep_instr
               & ~i_events.watchdog_timeout & ~i_events.warm_reset;
  property p_flags_locked;
    bus_wr && bus_idx == IDX_CORE_STATUS_FLAGS && quiet
    |=> o_status[4:3] == $past(o_status[4:3]);
  endproperty
  a_flags_locked: assert property (p_flags_locked) // R2
    else $error("Timeout or power-down flag changed by a bus write");
  property p_clear_status;
    i_core_op.valid && dest_status && i_core_op.op == OP_CLEAR_FILE_INSTR && quiet
    |=> o_status == {3'b000, $past(o_status[4:3]), 1'b1, $past(o_status[1:0])};
  endproperty
  a_clear_status: assert property (p_clear_status) // R3
    else $error("Clear of status did not give 000u u1uu");
  property p_sleep;
    i_events.sleep_instr && !i_events.watchdog_clear_instr
    |=> o_status[4:3] == 2'b10;
  endproperty
  a_sleep: assert property (p_sleep) // R9
    else $error("Sleep did not set timeout and clear power-down");
  property p_timeout;
    i_events.watchdog_timeout && !i_events.sleep_instr
      && !i_events.watchdog_clear_instr
    |=> !o_status[BIT_TIMEOUT] && o_status[BIT_POWER_DOWN] == $past(o_status[BIT_POWER_DOWN]);
  endproperty
  a_timeout: assert property (p_timeout) // R8
    else $error("Watchdog timeout did not clear the timeout flag");
  property p_wdt_clear;
    i_events.watchdog_clear_instr |=> o_status[4:3] == 2'b11;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) // R8
    else $error("Watchdog clear did not set both reset flags");
  property p_add_carry;
    i_core_op.valid && !dest_status && i_core_op.op == OP_ADD && quiet
    |=> o_status[BIT_CARRY] ==
        ($past({1'b0, i_core_op.f_val}) + $past({1'b0, i_core_op.w_val}) > 9'h0ff)
     && o_status[BIT_ZERO] == (o_core_res.value == 8'h00);
  endproperty
  a_add_carry: assert property (p_add_carry) // R12
    else $error("Add carry or zero flag wrong");
  property p_sub_borrow;
    i_core_op.valid && !dest_status && i_core_op.op == OP_SUB && quiet
    |=> o_status[BIT_CARRY] == ($past(i_core_op.f_val) >= $past(i_core_op.w_val))
     && o_status[BIT_DIGIT_CARRY]
        == ($past(i_core_op.f_val[3:0]) >= $past(i_core_op.w_val[3:0]));
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) // R5
    else $error("Subtract carry is not an inverted borrow");
  property p_rotate;
    i_core_op.valid && !dest_status && i_core_op.op == OP_RLF && quiet
    |=> o_status[BIT_CARRY] == $past(i_core_op.f_val[7])
     && o_core_res.value[0] == $past(o_status[BIT_CARRY]);
  endproperty
  a_rotate: assert property (p_rotate) // R13
    else $error("Rotate left did not shift through carry");
  property p_port_flag;
    i_events.warm_reset |=> !o_interrupt_control[BIT_PORT_CHANGE]
      && st.cmp_latch == $past(st.cmp_latch);
  endproperty
  a_port_flag: assert property (p_port_flag) // R14
    else $error("Warm reset kept the port-change flag or lost the latch");
  property p_pc_load;
    bus_wr && bus_idx == IDX_PROGRAM_COUNTER_LOW && !i_events.warm_reset
    |=> o_pc == {$past(st.program_counter_high_latch), $past(wbyte)};
  endproperty
  a_pc_load: assert property (p_pc_load) // R16
    else $error("Counter write did not take the high latch");
  property p_bus_ack;
    bus_req && !st.ack |=> !o_avs_waitrequest || !(i_avs_read | i_avs_write);
  endproperty
  a_bus_ack: assert property (p_bus_ack) // R17
    else $error("Bus request not answered after one wait state");
  c_clear_status: cover property (i_core_op.valid && dest_status
                                  && i_core_op.op == OP_CLEAR_FILE_INSTR);
  c_sleep_wake: cover property (i_events.sleep_instr ##[1:20]
                                i_events.watchdog_timeout);
  c_port_change: cover property ($rose(o_interrupt_control[BIT_PORT_CHANGE]));

endmodule
`default_nettype wire

// ### sim/tb_status_flags_bank_select.sv
`default_nettype none
module tb_status_flags_bank_select
  import sfb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Signals
  // ****************************************
  logic          clk;
  logic          rst_b;
  logic [11:0]   address;
  logic          read;
  logic          write;
  logic [31:0]   writedata;
  logic [3:0]    be;
  logic [31:0]   readdata;
  logic          waitreq;
  sfb_core_op_t  core_op;
  sfb_events_t   events;
  sfb_core_res_t core_res;
  logic [5:0]    pins;
  logic [7:0]    status;
  logic [8:0]    ind_addr;
  logic [8:0]    bank_base;
  logic [12:0]   pc;
  logic [7:0]    topt;
  logic [5:0]    adir;
  logic [5:0]    cdir;
  logic [7:0]    intc;
  logic [7:0]    rd;
  logic [2:0]    kb;
  int            num_errors;
  int            checks_done;

  initial clk = 1'b0;
  always #10 clk = ~clk;

  sfb_status_bank i_dut (
    .i_clk               (clk),
    .i_rst_b             (rst_b),
    .i_avs_address       (address),
    .i_avs_read          (read),
    .i_avs_write         (write),
    .i_avs_writedata     (writedata),
    .i_avs_byteenable    (be),
    .o_avs_readdata      (readdata),
    .o_avs_waitrequest   (waitreq),
    .i_core_op           (core_op),
    .i_events            (events),
    .o_core_res          (core_res),
    .i_port_a_pins       (pins),
    .o_status            (status),
    .o_indirect_addr     (ind_addr),
    .o_direct_bank_base  (bank_base),
    .o_pc                (pc),
    .o_timer_option      (topt),
    .o_port_a_dir        (adir),
    .o_port_c_dir        (cdir),
    .o_interrupt_control (intc)
  );

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus cycle; the request stands until waitrequest is seen low at an edge
  task automatic bus(input logic wr_en, input logic [8:0] idx, input logic [7:0] wd,
                     output logic [7:0] rdv);
    @(posedge clk);
    address   <= {1'b0, idx, 2'b00};
    writedata <= {24'h00_0000, wd};
    read      <= ~wr_en;
    write     <= wr_en;
    // Only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    rdv = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [8:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, rd);
  endtask

  task automatic rdchk(input logic [8:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, rd);
    chk(rd, exp);
  endtask

  // Results and flags land on the edge that takes the op
  task automatic op_run(input sfb_op_t o, input logic [6:0] fa, input logic [7:0] w,
                        input logic [7:0] f);
    @(posedge clk);
    core_op <= '{valid: 1'b1, op: o, file_addr: fa, bit_sel: 3'h0, w_val: w, f_val: f};
    @(posedge clk);
    core_op.valid <= 1'b0;
    #1;
  endtask

  task automatic alu(input sfb_op_t o, input logic [7:0] w, input logic [7:0] f,
                     input logic [7:0] res, input logic [2:0] fl, input logic [2:0] m);
    op_run(o, 7'h20, w, f);
    chk(core_res.valid, 1'b1);
    chk(core_res.value, res);
    chk(status[2:0] & m, fl & m);
  endtask

  task automatic pulse(input logic [3:0] e);
    @(posedge clk);
    events <= sfb_events_t'(e);
    @(posedge clk);
    events <= '0;
    #1;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst_b = 1'b0; read = 1'b0; write = 1'b0; address = '0; writedata = '0;
    be = 4'hf; core_op = '0; events = '0; pins = 6'h00;
    num_errors = 0; checks_done = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rdchk(IDX_CORE_STATUS_FLAGS, RST_STATUS);
    rdchk(IDX_TIMER_OPTION_CONTROL, 8'hff);
    rdchk(IDX_PROGRAM_COUNTER_LOW, 8'h00);
    rdchk(IDX_PORT_A_DIRECTION, 8'h3f);
    rdchk(IDX_PORT_C_DIRECTION, 8'h3f);
    rdchk(IDX_PC_HIGH_LATCH, 8'h00);
    rdchk(9'h186, 8'h00);
    $display("test reset values done");

    alu(OP_ADD, 8'h0f, 8'h01, 8'h10, 3'h2, 3'h7);
    alu(OP_ADD, 8'hff, 8'h01, 8'h00, 3'h7, 3'h7);
    alu(OP_SUB, 8'h01, 8'h10, 8'h0f, 3'h1, 3'h7);
    alu(OP_SUB, 8'h01, 8'h00, 8'hff, 3'h0, 3'h7);
    alu(OP_RLF, 8'h00, 8'h80, 8'h00, 3'h1, 3'h1);
    alu(OP_RRF, 8'h00, 8'h02, 8'h81, 3'h0, 3'h1);
    alu(OP_AND, 8'hf0, 8'h0f, 8'h00, 3'h4, 3'h4);
    alu(OP_IOR, 8'h00, 8'h00, 8'h00, 3'h4, 3'h4);
    alu(OP_XOR, 8'h5a, 8'h5b, 8'h01, 3'h0, 3'h4);
    alu(OP_MOVF, 8'h00, 8'h00, 8'h00, 3'h4, 3'h4);
    $display("test flag arithmetic done");

    wr(IDX_CORE_STATUS_FLAGS, 8'he7);
    rdchk(IDX_CORE_STATUS_FLAGS, 8'hff);
    wr(IDX_INDIRECT_POINTER, 8'h55);
    for (int k = 0; k < 8; k++) begin
      kb = k[2:0];
      wr(IDX_CORE_STATUS_FLAGS, {kb, 5'h00});
      chk(status, {kb, 5'h18});
      chk(ind_addr, {kb[2], 8'h55});
      chk(bank_base, {kb[1:0], 7'h00});
    end
    $display("test bank select done");

    wr(IDX_CORE_STATUS_FLAGS, 8'he3);
    chk(status, 8'hfb);
    op_run(OP_CLEAR_FILE_INSTR, FILE_STATUS, 8'h00, 8'h00);
    chk(status, 8'h1f);
    // Sum 1f + 01 lands in status, but the flags come from the add itself
    op_run(OP_ADD, FILE_STATUS, 8'h01, 8'h00);
    chk(status, 8'h3a);
    // Flagless ops on status take their result in every writable bit
    op_run(OP_BSF, FILE_STATUS, 8'h00, 8'h00);
    chk(status, 8'h3b);
    op_run(OP_BCF, FILE_STATUS, 8'h00, 8'h00);
    chk(status, 8'h3a);
    op_run(OP_NIBBLE_SWAP_INSTR, FILE_STATUS, 8'h00, 8'h00);
    chk(status, 8'hbb);
    op_run(OP_MOVE_FROM_W_INSTR, FILE_STATUS, 8'h04, 8'h00);
    chk(status, 8'h1c);
    $display("test status as destination done");

    pulse(4'h4);
    chk(status[4:3], 2'h2);
    pulse(4'h2);
    chk(status[4:3], 2'h0);
    pulse(4'h8);
    chk(status[4:3], 2'h3);
    $display("test reset flags done");

    wr(IDX_PC_HIGH_LATCH, 8'h15);
    chk(pc, 13'h0000);
    wr(IDX_PROGRAM_COUNTER_LOW, 8'h34);
    chk(pc, 13'h1534);
    be <= 4'h0;
    wr(IDX_PORT_A_DIRECTION, 8'h00);
    be <= 4'hf;
    rdchk(IDX_PORT_A_DIRECTION, 8'h3f);
    wr(IDX_PORT_C_DIRECTION, 8'h15);
    chk(cdir, 6'h15);
    wr(9'h186, 8'hab);
    rdchk(9'h186, 8'h00);
    wr(IDX_INDIRECT_DATA_PORT, 8'hab);
    rdchk(IDX_INDIRECT_DATA_PORT, 8'h00);
    $display("test map done");

    wr(IDX_CORE_STATUS_FLAGS, 8'he0);
    wr(IDX_TIMER_OPTION_CONTROL, 8'h00);
    rdchk(IDX_INTERRUPT_CONTROL, 8'h00);
    @(posedge clk);
    pins <= 6'h01;
    repeat (8) @(posedge clk);
    #1;
    chk(intc[BIT_PORT_CHANGE], 1'b1);
    pulse(4'h1);
    chk(intc[BIT_PORT_CHANGE], 1'b0);
    chk(status, 8'h18);
    chk(topt, 8'hff);
    chk(pc, 13'h0000);
    chk(adir, 6'h3f);
    // Flag can only come back if the latched pins survived the warm reset
    repeat (3) @(posedge clk);
    #1;
    chk(intc[BIT_PORT_CHANGE], 1'b1);
    rdchk(IDX_INTERRUPT_CONTROL, 8'h01);
    wr(IDX_INTERRUPT_CONTROL, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    chk(intc[BIT_PORT_CHANGE], 1'b0);
    $display("test warm reset done");
    conclude();
  end

  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    conclude();
  end

endmodule
`default_nettype wire
